// file: common/rel_pkg.sv
// constants, types and helpers shared by the recoverable error logger
`default_nettype none

package rel_pkg;

	// ****************************************
	// sizes
	// ****************************************
	localparam int NCPU  = 4;                   // logical processors served
	localparam int NBANK = 4;                   // error banks
	localparam int REC_W = 58;                  // stored record width

	// ****************************************
	// register byte offsets
	// ****************************************
	localparam logic [7:0] OFF_VIEW      = 8'h00; // processor whose view is read
	localparam logic [7:0] OFF_SHARE     = 8'h04; // bank sharing masks
	localparam logic [7:0] OFF_GSTAT     = 8'h08; // global check status of view
	localparam logic [7:0] OFF_COUNT     = 8'h0c; // logged event counter
	localparam logic [7:0] OFF_BANK_BASE = 8'h40; // banks, 0x10 apart
	localparam logic [7:0] BANK_MASK     = 8'hc0; // selects the bank window
	localparam logic [1:0] W_STATUS      = 2'h0;  // bank_error_status word
	localparam logic [1:0] W_AUX         = 2'h1;  // bank_aux_info word
	localparam logic [1:0] W_LOC         = 2'h2;  // bank_fault_location word

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [1:0]  VIEW_RST  = 2'h0;
	localparam logic [15:0] SHARE_RST = 16'hffff;

	// ****************************************
	// bank_error_status and global check status bit positions
	// ****************************************
	localparam int ST_VALID = 16;  // entry holds an error
	localparam int ST_LOST  = 17;  // a later error was lost
	localparam int ST_UC    = 18;  // uncorrected_flag
	localparam int ST_EN    = 19;  // reporting allowed
	localparam int ST_AUXV  = 20;  // aux_info_valid
	localparam int ST_LOCV  = 21;  // location_valid
	localparam int ST_PCC   = 22;  // context_corrupt_flag
	localparam int ST_S     = 23;  // recoverable signalling
	localparam int ST_AR    = 24;  // action_required_flag
	localparam int ST_OK    = 25;  // still treated as recoverable
	localparam int GS_RPV   = 0;   // restart_pointer_valid
	localparam int GS_EPV   = 1;   // error_pointer_valid
	localparam int GS_MCIP  = 2;   // check in progress

	// ****************************************
	// error code fields
	// ****************************************
	localparam logic       F_NORMAL   = 1'b0;    // bit 12, normal filtering
	localparam logic [2:0] MMM_SCRUB  = 3'b100;
	localparam logic [3:0] REQ_EVICT  = 4'b0111;
	localparam logic [3:0] REQ_DRD    = 4'b0011;
	localparam logic [3:0] REQ_IRD    = 4'b0101;
	localparam logic [1:0] TT_INSN    = 2'b00;
	localparam logic [1:0] TT_DATA    = 2'b01;
	localparam logic [1:0] TT_GEN     = 2'b10;
	localparam logic [1:0] LL_L0      = 2'b00;
	localparam logic [1:0] LL_L2      = 2'b10;
	localparam logic [2:0] MODE_PHYS  = 3'b010;  // physical address mode

	typedef enum logic [1:0] {
		KIND_SCRUB  = 2'h0,
		KIND_L3WB   = 2'h1,
		KIND_DLOAD  = 2'h2,
		KIND_IFETCH = 2'h3
	} rel_kind_t;

	typedef enum logic [2:0] {
		BS_IDLE = 3'b001,
		BS_BUSY = 3'b010,
		BS_ACK  = 3'b100
	} rel_bus_st_t;

	// cache hierarchy compound form
	function automatic logic [15:0] cache_code(input logic [3:0] rq, input logic [1:0] tt,
		input logic [1:0] ll);
		cache_code = {3'b000, F_NORMAL, 4'b0001, rq, tt, ll};
	endfunction

	// memory controller compound form
	function automatic logic [15:0] memctl_code(input logic [2:0] memory_txn_type, input logic [3:0] ch);
		memctl_code = {3'b000, F_NORMAL, 4'b0000, 1'b1, memory_txn_type, ch};
	endfunction

endpackage

`default_nettype wire

// file: design/rel_code_gen.sv
// error code and class decode for one incoming error event
`default_nettype none

module rel_code_gen
	import rel_pkg::*;
(
	input  wire logic [1:0]  kind,        // error kind, rel_kind_t
	input  wire logic [3:0]  channel,     // channel_field for scrubbing
	output logic      [15:0] code,        // arch_error_code
	output logic             action_req   // action_required_flag
);

	// ****************************************
	// compound code selection
	// ****************************************
	// the low nibble passes through so a channel or the generic 1111 lands in 0xC0..0xCF
	assign code = (kind == KIND_SCRUB)  ? memctl_code(MMM_SCRUB, channel) :
	              (kind == KIND_L3WB)   ? cache_code(REQ_EVICT, TT_GEN, LL_L2) :
	              (kind == KIND_DLOAD)  ? cache_code(REQ_DRD, TT_DATA, LL_L0) :
	                                      cache_code(REQ_IRD, TT_INSN, LL_L0);

	// consumption errors require action, scrub and writeback do not
	assign action_req = (kind == KIND_DLOAD) || (kind == KIND_IFETCH);

endmodule // rel_code_gen

`default_nettype wire

// file: design/rel_error_logger.sv
// recoverable machine error logger with avalon register access
// Behaviour
// - scrub error code 0xC0 plus channel nibble
// - writeback eviction error code is 0x17A
// - filtering bit 12 always logged zero
// - optional action flags set, action-required clear
// - required action flags set including action-required
// - data load error code is 0x134
// - instruction fetch error code is 0x150
// - every record carries aux and location valid
// - aux record holds physical mode and lsb
// - machine check pulses to every processor
// - only sharing processors see a bank entry
// - optional action: restart valid, error pointer clear
// - data load affected: restart clear, pointer set
// - fetch affected: both pointer flags clear
// - observers: restart valid set, pointer clear
// - the bank named by err_bank holds the record
// - invalid bank reads show no information
// - lost or corrupt entry is not recoverable
`default_nettype none

module rel_error_logger
	import rel_pkg::*;
(
	input  wire logic             mclk,                  // 50 MHz clock
	input  wire logic             sys_rst,               // async reset, high
	input  wire logic             err_valid,             // error event pulse
	input  wire logic [1:0]       err_kind,              // rel_kind_t
	input  wire logic [3:0]       err_channel,           // scrub channel or 1111
	input  wire logic [1:0]       err_bank,              // bank that logs it
	input  wire logic [1:0]       err_cpu,               // affected processor
	input  wire logic [31:0]      err_addr,              // faulting physical address
	input  wire logic [5:0]       err_addr_lsb,          // lowest valid address bit
	output logic      [NCPU-1:0]  machine_check_signal,  // broadcast pulse
	output logic      [NCPU-1:0]  restart_pointer_valid, // per processor
	output logic      [NCPU-1:0]  error_pointer_valid,   // per processor
	input  wire logic [7:0]       avs_address,           // byte address
	input  wire logic             avs_read,              // read request
	input  wire logic             avs_write,             // write request
	input  wire logic [31:0]      avs_writedata,         // write data
	output logic      [31:0]      avs_readdata,          // read data
	output logic                  avs_waitrequest        // stall
);

	// ****************************************
	// state
	// ****************************************
	rel_bus_st_t      st_ff, nxt_st;
	logic             wait_ff;
	logic [31:0]      rdata_ff;
	logic [1:0]       view_ff;
	logic [15:0]      share_ff;
	logic [15:0]      count_ff;
	logic [NBANK-1:0] valid_ff, nxt_valid;
	logic [NBANK-1:0] lost_ff, nxt_lost;
	logic [NCPU-1:0]  rpv_ff, nxt_rpv;
	logic [NCPU-1:0]  epv_ff, nxt_epv;
	logic [NCPU-1:0]  mcip_ff, nxt_mcip;
	logic [NCPU-1:0]  mce_ff;
	logic             snap_valid_ff;
	logic             snap_lost_ff;

	wire logic [15:0]      ev_code;
	wire logic             ev_ar;
	wire logic [REC_W-1:0] rec_rd;

	// ****************************************
	// event decode
	// ****************************************
	rel_code_gen u_code (
		.kind       (err_kind),
		.channel    (err_channel),
		.code       (ev_code),
		.action_req (ev_ar)
	);

	// ****************************************
	// register decode
	// ****************************************
	// a write lands only on the accept edge, when address and data are still held;
	// decoding at any other edge could act on a request the master is still setting up
	wire logic       acc_wr   = (st_ff == BS_ACK) && avs_write;
	wire logic       is_view  = (avs_address == OFF_VIEW);
	wire logic       is_share = (avs_address == OFF_SHARE);
	wire logic       is_gstat = (avs_address == OFF_GSTAT);
	wire logic       is_count = (avs_address == OFF_COUNT);
	wire logic       is_bank  = ((avs_address & BANK_MASK) == OFF_BANK_BASE);
	wire logic [1:0] rd_bank  = avs_address[5:4];
	wire logic [1:0] rd_word  = avs_address[3:2];
	wire logic [NBANK-1:0] ev_vec  = err_valid ? (4'h1 << err_bank) : 4'h0;
	wire logic [NBANK-1:0] clr_vec = (acc_wr && is_bank && rd_word == W_STATUS &&
		!avs_writedata[ST_VALID]) ? (4'h1 << rd_bank) : 4'h0;

	// a bank cleared in the same cycle counts as free, so the new error is kept
	wire logic fresh = err_valid && (!valid_ff[err_bank] || clr_vec[err_bank]);

	// ****************************************
	// record store
	// ****************************************
	// one row holds code, action flag, mode, lsb and address: never half written
	wire logic [REC_W-1:0] rec_wr = {ev_ar, MODE_PHYS, err_addr_lsb, err_addr, ev_code};
	rel_rec_mem u_mem (
		.mclk     (mclk),
		.sys_rst  (sys_rst),
		.we       (fresh),
		.waddr    (err_bank),
		.wdata    (rec_wr),
		.raddr    (rd_bank),
		.rdata_ff (rec_rd)
	);

	// ****************************************
	// bank valid and lost flags
	// ****************************************
	// an error into an occupied bank keeps the old record and marks it lost
	always_comb begin
		for (int i = 0; i < NBANK; i++) begin
			if (ev_vec[i]) begin
				nxt_valid[i] = 1'b1;
				nxt_lost[i]  = (lost_ff[i] | valid_ff[i]) & ~clr_vec[i];
			end else begin
				nxt_valid[i] = valid_ff[i] & ~clr_vec[i];
				nxt_lost[i]  = lost_ff[i] & ~clr_vec[i];
			end
		end
	end

	// ****************************************
	// global check status per processor
	// ****************************************
	// the set of check-in-progress wins over a software clear in the same cycle
	always_comb begin
		for (int i = 0; i < NCPU; i++) begin
			nxt_rpv[i]  = rpv_ff[i];
			nxt_epv[i]  = epv_ff[i];
			nxt_mcip[i] = mcip_ff[i];
			if (acc_wr && is_gstat && view_ff == 2'(i) && !avs_writedata[GS_MCIP]) begin
				nxt_mcip[i] = 1'b0;
			end
			if (err_valid) begin
				nxt_mcip[i] = 1'b1;
				if (ev_ar && err_cpu == 2'(i)) begin
					nxt_rpv[i] = 1'b0;
					nxt_epv[i] = (err_kind == KIND_DLOAD);
				end else begin
					nxt_rpv[i] = 1'b1;
					nxt_epv[i] = 1'b0;
				end
			end
		end
	end

	// ****************************************
	// read data compose
	// ****************************************
	// flags snapped on the same edge as the row, so a read never mixes two records
	wire logic vis_ok = share_ff[{rd_bank, view_ff}] && snap_valid_ff;
	wire logic rec_ar = rec_rd[REC_W-1];
	// only recoverable classes reach this logger, so the context is never corrupt
	wire logic ctx_corrupt = 1'b0;
	logic [31:0] stat_word;
	logic [31:0] gstat_word;

	// status word placed bit by bit at the named positions
	always_comb begin
		stat_word           = 32'h0000_0000;
		stat_word[15:0]     = rec_rd[15:0];
		stat_word[ST_VALID] = 1'b1;                          // gated by vis_ok
		stat_word[ST_LOST]  = snap_lost_ff;
		stat_word[ST_UC]    = 1'b1;
		stat_word[ST_EN]    = 1'b1;
		stat_word[ST_AUXV]  = 1'b1;
		stat_word[ST_LOCV]  = 1'b1;
		stat_word[ST_PCC]   = ctx_corrupt;
		stat_word[ST_S]     = 1'b1;
		stat_word[ST_AR]    = rec_ar;
		stat_word[ST_OK]    = ~(snap_lost_ff | ctx_corrupt);
	end

	wire logic [31:0] aux_word  = {23'h00_0000, rec_rd[REC_W-2:REC_W-4], rec_rd[REC_W-5:48]};
	wire logic [31:0] bank_word = !vis_ok ? 32'h0000_0000 :
	                              (rd_word == W_STATUS) ? stat_word :
	                              (rd_word == W_AUX)    ? aux_word :
	                              (rd_word == W_LOC)    ? rec_rd[47:16] : 32'h0000_0000;

	// global status of the processor chosen by the view register
	always_comb begin
		gstat_word          = 32'h0000_0000;
		gstat_word[GS_RPV]  = rpv_ff[view_ff];
		gstat_word[GS_EPV]  = epv_ff[view_ff];
		gstat_word[GS_MCIP] = mcip_ff[view_ff];
	end
	wire logic [31:0] rd_mux =
		is_view  ? {30'h0000_0000, view_ff} :
		is_share ? {16'h0000, share_ff} :
		is_gstat ? gstat_word :
		is_count ? {16'h0000, count_ff} :
		is_bank  ? bank_word : 32'h0000_0000;

	// ****************************************
	// bus handshake state
	// ****************************************
	// fixed three-edge answer covers the registered record read
	// the answer never depends on the address, so software sees one latency everywhere;
	// the price is two wait cycles even for the plain registers
	always_comb begin
		case (st_ff)
			BS_IDLE: nxt_st = (avs_read || avs_write) ? BS_BUSY : BS_IDLE;
			BS_BUSY: nxt_st = BS_ACK;
			BS_ACK:  nxt_st = BS_IDLE;
			default: nxt_st = BS_IDLE;
		endcase
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			st_ff    <= BS_IDLE;
			wait_ff  <= 1'b1;
			rdata_ff <= 32'h0000_0000;
		end else begin
			st_ff    <= nxt_st;
			wait_ff  <= (st_ff != BS_BUSY);
			rdata_ff <= (st_ff == BS_BUSY) ? rd_mux : rdata_ff;
		end
	end

	// ****************************************
	// software registers
	// ****************************************
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			view_ff  <= VIEW_RST;
			share_ff <= SHARE_RST;
		end else if (acc_wr) begin
			view_ff  <= is_view ? avs_writedata[1:0] : view_ff;
			share_ff <= is_share ? avs_writedata[15:0] : share_ff;
		end
	end

	// ****************************************
	// error state
	// ****************************************
	// bank flags follow the next values built above
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			valid_ff <= '0;
			lost_ff  <= '0;
		end else begin
			valid_ff <= nxt_valid;
			lost_ff  <= nxt_lost;
		end
	end

	// ****************************************
	// global check status registers
	// ****************************************
	// pointer flags hold until the next event, so a slow handler still reads them
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			rpv_ff  <= '0;
			epv_ff  <= '0;
			mcip_ff <= '0;
		end else begin
			rpv_ff  <= nxt_rpv;
			epv_ff  <= nxt_epv;
			mcip_ff <= nxt_mcip;
		end
	end

	// ****************************************
	// check pulse and event count
	// ****************************************
	// back-to-back events merge into one longer pulse; the counter wraps silently
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			mce_ff   <= '0;
			count_ff <= 16'h0000;
		end else begin
			mce_ff   <= {NCPU{err_valid}};
			count_ff <= count_ff + 16'(err_valid);
		end
	end

	// ****************************************
	// read snapshot
	// ****************************************
	// taken every edge so the flags match the record row read on the same edge
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			snap_valid_ff <= 1'b0;
			snap_lost_ff  <= 1'b0;
		end else begin
			snap_valid_ff <= valid_ff[rd_bank];
			snap_lost_ff  <= lost_ff[rd_bank];
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign machine_check_signal  = mce_ff;
	assign restart_pointer_valid = rpv_ff;
	assign error_pointer_valid   = epv_ff;
	assign avs_readdata          = rdata_ff;
	assign avs_waitrequest       = wait_ff;

endmodule // rel_error_logger

`default_nettype wire

// file: design/rel_rec_mem.sv
// small record store for the error banks, registered read
`default_nettype none

module rel_rec_mem
	import rel_pkg::*;
(
	input  wire logic             mclk,      // clock
	input  wire logic             sys_rst,   // async reset, high
	input  wire logic             we,        // write whole record
	input  wire logic [1:0]       waddr,     // bank written
	input  wire logic [REC_W-1:0] wdata,     // record written
	input  wire logic [1:0]       raddr,     // bank read
	output logic      [REC_W-1:0] rdata_ff   // record read, one cycle late
);

	logic [REC_W-1:0] mem [NBANK];

	// one write of the full record keeps code, flags and address together
	always_ff @(posedge mclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// read-first: a same-edge write is seen on the next read
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_ff <= '0;
		end else begin
			rdata_ff <= mem[raddr];
		end
	end

endmodule // rel_rec_mem

`default_nettype wire

// file: testbench/rel_chk_sva.sv
// port assertions for the recoverable error logger
`default_nettype none
module rel_chk
	import rel_pkg::*;
(
	input wire logic            mclk,                  // clock
	input wire logic            sys_rst,               // async reset
	input wire logic            err_valid,             // event pulse
	input wire logic [1:0]      err_kind,              // event kind
	input wire logic [1:0]      err_cpu,               // affected cpu
	input wire logic [NCPU-1:0] machine_check_signal,  // broadcast
	input wire logic [NCPU-1:0] restart_pointer_valid, // per cpu
	input wire logic [NCPU-1:0] error_pointer_valid,   // per cpu
	input wire logic            avs_read,              // bus read
	input wire logic            avs_write,             // bus write
	input wire logic            avs_waitrequest        // bus stall
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	// one-hot of the affected cpu, not registered; $past reads it at the next edge
	logic [3:0] hit;
	assign hit = 4'h1 << err_cpu;
	// ****
	// assertions
	// ****
	a_mcs_all: assert property ($past(err_valid) |-> machine_check_signal == 4'hf)
		else $error("check signal not broadcast");
	a_mcs_idle: assert property (!$past(err_valid) |-> machine_check_signal == 4'h0)
		else $error("check signal without event");
	a_opt_ptrs: assert property (err_valid && !err_kind[1] |=>
		restart_pointer_valid == 4'hf && error_pointer_valid == 4'h0)
		else $error("optional action pointer flags wrong");
	a_load_ptrs: assert property (err_valid && err_kind == 2'h2 |=>
		restart_pointer_valid == ~$past(hit) && error_pointer_valid == $past(hit))
		else $error("data load pointer flags wrong");
	a_fetch_ptrs: assert property (err_valid && err_kind == 2'h3 |=>
		restart_pointer_valid == ~$past(hit) && error_pointer_valid == 4'h0)
		else $error("fetch pointer flags wrong");
	a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |->
		##[1:2] !avs_waitrequest) else $error("bus answer late");
	a_ack_single: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("accept longer than one cycle");
	a_ack_cause: assert property (!avs_waitrequest |->
		$past(avs_read || avs_write, 2) && (avs_read || avs_write))
		else $error("accept without request");
	// main scenarios reached
	c_scrub: cover property (err_valid && err_kind == 2'h0);
	c_load: cover property (err_valid && err_kind == 2'h2);
	c_fetch: cover property (err_valid && err_kind == 2'h3);
endmodule // rel_chk
bind rel_error_logger rel_chk u_chk (.mclk, .sys_rst, .err_valid, .err_kind, .err_cpu,
	.machine_check_signal, .restart_pointer_valid, .error_pointer_valid, .avs_read,
	.avs_write, .avs_waitrequest);
`default_nettype wire

// file: testbench/rel_sw_model.sv
// handler software model: decides per cpu whether the old context may resume
`default_nettype none
module rel_sw_model
	import rel_pkg::*;
(
	input  wire logic            mclk,                  // clock
	input  wire logic            sys_rst,               // async reset
	input  wire logic [NCPU-1:0] machine_check_signal,  // check pulse
	input  wire logic [NCPU-1:0] restart_pointer_valid, // restart allowed
	output logic      [NCPU-1:0] resume_ok_ff,          // 0: new stream
	output logic      [NCPU-1:0] page_retire_ff         // page taken out of use
);
	timeunit 1ns;
	timeprecision 1ns;
	// the affected processor, restart not flagged, stops using the faulty page for good
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			page_retire_ff <= '0;
		end else begin
			page_retire_ff <= page_retire_ff | (machine_check_signal & ~restart_pointer_valid);
		end
	end
	// resume only where restart is flagged; elsewhere a fresh stream is started
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			resume_ok_ff <= '0;
		end else begin
			resume_ok_ff <= (machine_check_signal & restart_pointer_valid)
				| (~machine_check_signal & resume_ok_ff);
		end
	end
endmodule // rel_sw_model
`default_nettype wire

// file: testbench/tb.sv
// self-checking bench for the recoverable error logger
`default_nettype none
module tb
	import rel_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        mclk, sys_rst, err_valid, avs_read, avs_write, avs_waitrequest;
	logic [1:0]  err_kind, err_bank, err_cpu;
	logic [3:0]  err_channel, mcs, rpv, epv, resume, retire;
	logic [5:0]  err_addr_lsb;
	logic [7:0]  avs_address;
	logic [31:0] err_addr, avs_writedata, avs_readdata, rdv, adr;
	int          n_errors, n_compared;
	rel_error_logger u_dut (.mclk, .sys_rst, .err_valid, .err_kind, .err_channel,
		.err_bank, .err_cpu, .err_addr, .err_addr_lsb, .machine_check_signal(mcs),
		.restart_pointer_valid(rpv), .error_pointer_valid(epv), .avs_address,
		.avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest);
	rel_sw_model u_sw (.mclk, .sys_rst, .machine_check_signal(mcs),
		.restart_pointer_valid(rpv), .resume_ok_ff(resume), .page_retire_ff(retire));
	// ****
	// tasks
	// ****
	task automatic end_sim();
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	// request held until the edge that samples waitrequest low
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int i;
		@(posedge mclk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= wd;
		for (i = 0; i < 16; i++) begin
			@(posedge mclk);
			if (avs_waitrequest === 1'b0) break;
		end
		rdv = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (i == 16) begin
			n_errors++;
			$display("Error bus timeout");
			end_sim();
		end
	endtask
	task automatic chk(input logic [7:0] a, input logic [31:0] e, input string nm);
		bus(1'b0, a, 32'h0000_0000);
		cmp(nm, e, rdv);
	endtask
	task automatic ev(input logic [1:0] k, input logic [1:0] b, input logic [3:0] ch);
		@(posedge mclk);
		err_valid <= 1'b1;
		err_kind <= k;
		err_bank <= b;
		err_cpu <= b;
		err_channel <= ch;
		err_addr <= adr;
		@(posedge mclk);
		err_valid <= 1'b0;
	endtask
	// status word built from the code and the class flags
	function automatic logic [31:0] st_exp(input logic [1:0] k, input logic [3:0] ch);
		logic [15:0] c;
		case (k)
			2'h0: c = {12'h00c, ch};
			2'h1: c = 16'h017a;
			2'h2: c = 16'h0134;
			default: c = 16'h0150;
		endcase
		return {6'h00, k[1] ? 10'h3bd : 10'h2bd, c};
	endfunction
	// ****
	// sequence
	// ****
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	initial begin
		{sys_rst, err_valid, avs_read, avs_write} <= 4'b1000;
		{err_kind, err_bank, err_cpu, err_channel} <= 10'h000;
		{err_addr, avs_writedata, avs_address} <= 72'h0;
		err_addr_lsb <= 6'h0c;
		repeat (16) @(posedge mclk);
		sys_rst <= 1'b0;
		chk(OFF_VIEW, 32'h0000_0000, "view");
		chk(OFF_SHARE, 32'h0000_ffff, "share");
		chk(OFF_GSTAT, 32'h0000_0000, "gstat");
		chk(8'h30, 32'h0000_0000, "unmapped");
		chk(OFF_BANK_BASE, 32'h0000_0000, "bank0");
		$display("test reset done");
		for (int k = 0; k < 4; k++) begin
			adr = 32'h1000_0000 + 32'(k * 64);
			ev(2'(k), 2'(k), 4'h5);
			bus(1'b1, OFF_VIEW, 32'(k));
			chk(OFF_BANK_BASE + 8'(k * 16), st_exp(2'(k), 4'h5), "status");
			chk(OFF_BANK_BASE + 8'(k * 16 + 4), {23'h0, 3'b010, 6'h0c}, "aux");
			chk(OFF_BANK_BASE + 8'(k * 16 + 8), adr, "location");
			chk(OFF_GSTAT, {29'h0, 1'b1, k == 2, k < 2}, "gstat");
			cmp("resume", k < 2 ? 32'hf : {28'h0, ~(4'h1 << k)}, {28'h0, resume});
			bus(1'b1, OFF_VIEW, 32'(k ^ 1));
			chk(OFF_GSTAT, 32'h0000_0005, "observer");
		end
		cmp("retire", 32'h0000_000c, {28'h0, retire});
		$display("test kinds done");
		bus(1'b1, OFF_SHARE, 32'h0000_0001);
		bus(1'b1, OFF_VIEW, 32'h0000_0001);
		chk(OFF_BANK_BASE, 32'h0000_0000, "unshared");
		bus(1'b1, OFF_VIEW, 32'h0000_0000);
		chk(OFF_BANK_BASE, st_exp(2'h0, 4'h5), "shared");
		bus(1'b1, OFF_SHARE, 32'h0000_ffff);
		$display("test sharing done");
		adr = 32'h2000_0000;
		ev(2'h2, 2'h0, 4'hf);
		chk(OFF_BANK_BASE, st_exp(2'h0, 4'h5) ^ 32'h0202_0000, "lost");
		chk(OFF_BANK_BASE + 8'h08, 32'h1000_0000, "kept");
		bus(1'b1, OFF_BANK_BASE, 32'h0000_0000);
		chk(OFF_BANK_BASE, 32'h0000_0000, "cleared");
		chk(OFF_BANK_BASE + 8'h04, 32'h0000_0000, "aux cleared");
		ev(2'h0, 2'h0, 4'hf);
		chk(OFF_BANK_BASE, st_exp(2'h0, 4'hf), "generic");
		chk(OFF_COUNT, 32'h0000_0006, "count");
		bus(1'b1, OFF_GSTAT, 32'h0000_0000);
		chk(OFF_GSTAT, 32'h0000_0001, "mcip clear");
		$display("test lost done");
		end_sim();
	end
endmodule // tb
`default_nettype wire
